// File: logic/txsc_pkg.sv
// Constants, types and register helpers of the transmit state controller
package txsc_pkg;

   // Core clock and documented times
   localparam int CLK_NS        = 5;
   localparam int NS_PER_US     = 1000;
   localparam int OSC_SETTLE_US = 400;
   localparam int SYNTH_LOCK_US = 370;
   localparam int MS_US         = 1000;
   localparam int US_CYC   = (NS_PER_US + CLK_NS - 1) / CLK_NS;
   localparam int OSC_CYC  = (OSC_SETTLE_US * NS_PER_US + CLK_NS - 1) / CLK_NS;
   localparam int TUNE_CYC = (SYNTH_LOCK_US * NS_PER_US + CLK_NS - 1) / CLK_NS;
   localparam int MS_CYC   = (MS_US * NS_PER_US + CLK_NS - 1) / CLK_NS;

   // Amplifier ramp
   localparam int         RAMP_STEPS     = 8;
   localparam int         RAMP_BASE      = US_CYC / RAMP_STEPS;
   localparam int         RAMP_TOP_SHIFT = 10;
   localparam logic [3:0] RAMP_MAX       = 4'hB;

   // Register byte addresses
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_STOP = 8'h04;
   localparam logic [7:0] A_FREQ = 8'h08;
   localparam logic [7:0] A_DEV  = 8'h0C;
   localparam logic [7:0] A_SR   = 8'h10;
   localparam logic [7:0] A_STAT = 8'h14;
   localparam logic [2:0] NVM_LAST = 3'h4;

   // Field positions
   localparam int CTRL_FALL = 0;
   localparam int CTRL_POL  = 1;
   localparam int CTRL_MOD  = 2;
   localparam int CTRL_RAMP = 4;
   localparam int CTRL_PWR  = 8;
   localparam int CTRL_CRST = 16;
   localparam int DEV_XLD   = 8;

   // Stop time coding
   localparam logic [3:0] STOP_LONG      = 4'h8;
   localparam logic [6:0] STOP_SHORT_MIN = 7'h02;
   localparam logic [3:0] STOP_LONG_OFS  = 4'h6;
   localparam logic [6:0] STOP_LONG_STEP = 7'h0A;

   // AXI responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      ST_SLEEP = 2'b00,
      ST_OSC   = 2'b01,
      ST_TUNE  = 2'b10,
      ST_TX    = 2'b11
   } txsc_state_e;

   typedef enum logic [1:0] {
      MOD_FSK  = 2'b00,
      MOD_GFSK = 2'b01,
      MOD_OOK  = 2'b10
   } txsc_mod_e;

   typedef struct packed {
      logic        fall;
      logic        pol;
      txsc_mod_e   mod;
      logic [3:0]  ramp;
      logic [4:0]  pwr;
      logic [3:0]  stop;
      logic [19:0] freq;
      logic [6:0]  dev;
      logic [5:0]  xld;
      logic [9:0]  sr;
   } txsc_cfg_s;

   // Settings after reset
   localparam txsc_cfg_s CFG_RST = '{
      fall: 1'b0, pol: 1'b0, mod: MOD_FSK, ramp: 4'h0, pwr: 5'h14,
      stop: 4'h8, freq: 20'hD3FFE, dev: 7'h23, xld: 6'h0F, sr: 10'h018};

   function automatic logic [31:0] cfg_rd(txsc_cfg_s c, logic [7:0] a);
      logic [31:0] w;
      w = '0;
      case (a)
         A_CTRL: begin
            w[CTRL_FALL]       = c.fall;
            w[CTRL_POL]        = c.pol;
            w[CTRL_MOD +: 2]   = c.mod;
            w[CTRL_RAMP +: 4]  = c.ramp;
            w[CTRL_PWR +: 5]   = c.pwr;
         end
         A_STOP: w[3:0] = c.stop;
         A_FREQ: w[19:0] = c.freq;
         A_DEV: begin
            w[6:0]           = c.dev;
            w[DEV_XLD +: 6]  = c.xld;
         end
         A_SR: w[9:0] = c.sr;
         default: w = '0;
      endcase
      return w;
   endfunction

   // Byte-lane merge then field update
   function automatic txsc_cfg_s cfg_wr(txsc_cfg_s c, logic [7:0] a,
                                        logic [31:0] d, logic [3:0] s);
      logic [31:0] w;
      txsc_cfg_s   n;
      w = cfg_rd(c, a);
      n = c;
      for (int i = 0; i < 4; i++) begin
         if (s[i]) begin
            w[i*8 +: 8] = d[i*8 +: 8];
         end
      end
      case (a)
         A_CTRL: begin
            n.fall = w[CTRL_FALL];
            n.pol  = w[CTRL_POL];
            n.mod  = txsc_mod_e'(w[CTRL_MOD +: 2]);
            n.ramp = w[CTRL_RAMP +: 4];
            n.pwr  = w[CTRL_PWR +: 5];
         end
         A_STOP: n.stop = w[3:0];
         A_FREQ: n.freq = w[19:0];
         A_DEV: begin
            n.dev = w[6:0];
            n.xld = w[DEV_XLD +: 6];
         end
         A_SR: n.sr = w[9:0];
         default: n = c;
      endcase
      return n;
   endfunction

   function automatic logic map_ok(logic [7:0] a);
      return (a[1:0] == 2'h0) && (a <= A_STAT);
   endfunction

   // Stop code to milliseconds
   function automatic logic [6:0] stop_ms(logic [3:0] c);
      return (c < STOP_LONG) ? 7'(c) + STOP_SHORT_MIN
                             : 7'(c - STOP_LONG_OFS) * STOP_LONG_STEP;
   endfunction

endpackage

// File: logic/txsc_sync.sv
// Two-flop synchroniser for the data pin level
`timescale 1ns/1ps
module txsc_sync (
   // Clock and reset
   input  wire logic i_core_clk,
   input  wire logic i_rst_n,
   // Pin in, level out
   input  wire logic i_pin,
   output logic      o_level
);
   typedef struct packed {
      logic meta;
      logic q;
   } txsc_sync_s;

   txsc_sync_s r;
   txsc_sync_s n;

   always_comb begin
      n.meta = i_pin;
      n.q    = r.meta;
      if (!i_rst_n) begin
         n = '0;
      end
   end

   always_ff @(posedge i_core_clk) begin
      r <= n;
   end

   assign o_level = r.q;
endmodule // txsc_sync

// File: logic/txsc_ramp.sv
// Amplifier level ramp for OOK keying
`timescale 1ns/1ps
module txsc_ramp import txsc_pkg::*; #(
   parameter int STEPS = RAMP_STEPS,
   parameter int BASE  = RAMP_BASE,
   parameter int LW    = $clog2(RAMP_STEPS + 1)
) (
   // Clock and reset
   input  wire logic          i_core_clk,
   input  wire logic          i_rst_n,
   // Control
   input  wire logic          i_act,
   input  wire logic          i_ook,
   input  wire logic          i_bit,
   input  wire logic [3:0]    i_code,
   // Amplifier drive
   output logic [LW-1:0]      o_level,
   output logic               o_pa_on
);
   localparam int CW = $clog2(BASE << RAMP_TOP_SHIFT) + 1;

   typedef struct packed {
      logic [LW-1:0] lvl;
      logic [CW-1:0] cnt;
      logic          on;
   } txsc_ramp_s;

   txsc_ramp_s r;
   txsc_ramp_s n;

   always_comb begin
      logic [3:0]    code;
      logic [CW-1:0] per;
      logic [LW-1:0] tgt;
      code = (i_code > RAMP_MAX) ? RAMP_MAX : i_code;
      per  = (code == 4'h0) ? '0 : CW'(BASE << (code - 4'h1));
      tgt  = (i_act && (!i_ook || i_bit)) ? LW'(STEPS) : '0;
      n    = r;
      if (!i_act || !i_ook || code == 4'h0) begin
         n.lvl = tgt;
         n.cnt = '0;
      end else if (r.lvl == tgt) begin
         n.cnt = '0;
      end else if (r.cnt == per - CW'(1)) begin
         n.cnt = '0;
         n.lvl = (tgt > r.lvl) ? r.lvl + LW'(1) : r.lvl - LW'(1);
      end else begin
         n.cnt = r.cnt + CW'(1);
      end
      n.on = (n.lvl != '0);
      if (!i_rst_n) begin
         n = '0;
      end
   end

   always_ff @(posedge i_core_clk) begin
      r <= n;
   end

   assign o_level = r.lvl;
   assign o_pa_on = r.on;

   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (!i_rst_n);

   AST_RAMP_NOT_OOK: assert property (
      i_act && !i_ook |=> o_level == LW'(STEPS) && o_pa_on)
      else $error("non-OOK amplifier not at full level");
   AST_RAMP_ZERO: assert property (
      i_act && i_ook && i_code == 4'h0 && i_bit |=> o_level == LW'(STEPS))
      else $error("zero ramp did not reach full level at once");
   AST_RAMP_STEP: assert property (
      i_act && i_ook && i_code != 4'h0 |=> o_level == $past(o_level)
         || o_level == $past(o_level) + LW'(1) || o_level + LW'(1) == $past(o_level))
      else $error("ramp moved more than one step");
   COV_RAMP_FULL: cover property (i_ook && i_code != 4'h0 && o_level == LW'(STEPS));
endmodule // txsc_ramp

// File: logic/txsc_top.sv
// Transmit state controller: working states, settings registers, AXI4-Lite slave
`timescale 1ns/1ps

// What this block does
// - Exactly four working states: sleep, oscillator wake-up, tune, transmit.
// - Sleep keeps oscillator and synthesizer off, and the amplifier off from its second cycle.
// - Configured data-pin edge in sleep enters wake-up and starts the oscillator.
// - Start-edge setting picks rising or falling edge; rising after reset.
// - After settling, tune for the synthesizer lock time, 370 us, then transmit.
// - Amplifier off and data-pin bits dropped until tuning is complete.
// - Transmit modulates data-pin bits and drives them through the amplifier.
// - Data pin held low for the stop time ends transmission.
// - Stop time 2 to 9 ms or 20 to 90 ms; 20 ms after reset.
// - Core reset command stops transmission within 1 ms.
// - Ramp time 0 or 1 to 1024 us in powers of two, OOK only.
// - Zero ramp setting raises the amplifier to full power at once.
// - Ramp down lasts as long as ramp up.
// - Settings load from non-volatile memory at power-up, kept until rewritten.
// - Output power -10 to +13 dBm in 1 dB steps.
// - Polarity setting picks which logic level maps to the higher frequency.
// - Modulation FSK, GFSK or OOK, FSK default; symbol rate 2.4 ksps, GFSK only.
// - Carrier 240 to 960 MHz in 1 kHz steps, default 868.35 MHz.
// - Crystal load 10 to 22 pF in 0.33 pF steps, default 15 pF.
// - FSK deviation 1 to 100 kHz, default 35 kHz.
// - Either stop path returns the device to sleep.
module txsc_top import txsc_pkg::*; #(
   parameter int P_OSC_CYC  = OSC_CYC,
   parameter int P_TUNE_CYC = TUNE_CYC,
   parameter int P_MS_CYC   = MS_CYC
) (
   // Clock and reset
   input  wire logic        i_core_clk,
   input  wire logic        i_rst_n,
   // AXI4-Lite write address
   input  wire logic        i_awvalid,
   output logic             o_awready,
   input  wire logic [7:0]  i_awaddr,
   // AXI4-Lite write data
   input  wire logic        i_wvalid,
   output logic             o_wready,
   input  wire logic [31:0] i_wdata,
   input  wire logic [3:0]  i_wstrb,
   // AXI4-Lite write response
   output logic             o_bvalid,
   input  wire logic        i_bready,
   output logic [1:0]       o_bresp,
   // AXI4-Lite read
   input  wire logic        i_arvalid,
   output logic             o_arready,
   input  wire logic [7:0]  i_araddr,
   output logic             o_rvalid,
   input  wire logic        i_rready,
   output logic [31:0]      o_rdata,
   output logic [1:0]       o_rresp,
   // Data pin and core reset command
   input  wire logic        i_data_pin,
   input  wire logic        i_core_rst_cmd,
   // Non-volatile settings memory
   output logic             o_nvm_req,
   output logic [7:0]       o_nvm_addr,
   input  wire logic        i_nvm_valid,
   input  wire logic [31:0] i_nvm_data,
   // Radio controls
   output logic [1:0]       o_state,
   output logic             o_osc_en,
   output logic             o_synth_en,
   output logic             o_pa_en,
   output logic [3:0]       o_pa_level,
   output logic             o_mod_bit,
   // Settings to the radio
   output logic [1:0]       o_mod,
   output logic [19:0]      o_carrier_khz,
   output logic [6:0]       o_dev_khz,
   output logic [4:0]       o_pwr_code,
   output logic [5:0]       o_xtal_load,
   output logic [9:0]       o_sym_rate,
   output logic [3:0]       o_ramp_code
);
   localparam int CMAX = (P_OSC_CYC > P_TUNE_CYC) ? P_OSC_CYC : P_TUNE_CYC;
   localparam int CW   = $clog2(CMAX) + 1;
   localparam int PW   = $clog2(P_MS_CYC) + 1;

   typedef struct packed {
      txsc_state_e  state;
      logic [CW-1:0] cnt;
      logic [PW-1:0] pre;
      logic [6:0]   low_ms;
      logic         data_d;
      logic         tx_bit;
      logic         mod_bit;
      logic         osc_en;
      logic         synth_en;
      logic         loaded;
      logic         nvm_req;
      logic [2:0]   nvm_idx;
      txsc_cfg_s    cfg;
      logic         awready;
      logic         aw_got;
      logic [7:0]   awaddr;
      logic         wready;
      logic         w_got;
      logic [31:0]  wdata;
      logic [3:0]   wstrb;
      logic         bvalid;
      logic [1:0]   bresp;
      logic         arready;
      logic         rvalid;
      logic [31:0]  rdata;
      logic [1:0]   rresp;
   } txsc_top_s;

   txsc_top_s r;
   txsc_top_s n;
   logic      d_sync;
   logic      pa_on;
   logic      wr_do;
   logic      core_cmd;
   logic      start_edge;

   txsc_sync u_sync (
      .i_core_clk (i_core_clk),
      .i_rst_n    (i_rst_n),
      .i_pin      (i_data_pin),
      .o_level    (d_sync)
   );

   txsc_ramp #(
      .STEPS (RAMP_STEPS),
      .BASE  (RAMP_BASE),
      .LW    (4)
   ) u_ramp (
      .i_core_clk (i_core_clk),
      .i_rst_n    (i_rst_n),
      .i_act      (r.state == ST_TX),
      .i_ook      (r.cfg.mod == MOD_OOK),
      .i_bit      (r.tx_bit),
      .i_code     (r.cfg.ramp),
      .o_level    (o_pa_level),
      .o_pa_on    (pa_on)
   );

   assign wr_do = r.aw_got && r.w_got && !r.bvalid;
   assign core_cmd = i_core_rst_cmd || (wr_do && r.awaddr == A_CTRL
                     && r.wstrb[CTRL_CRST / 8] && r.wdata[CTRL_CRST]);
   assign start_edge = r.cfg.fall ? (!d_sync && r.data_d)
                                  : (d_sync && !r.data_d);

   always_comb begin
      n = r;
      n.data_d = d_sync;

      // Power-up settings load
      if (!r.loaded) begin
         n.nvm_req = 1'b1;
         if (r.nvm_req && i_nvm_valid) begin
            n.cfg = cfg_wr(r.cfg, {3'h0, r.nvm_idx, 2'h0}, i_nvm_data, 4'hF);
            n.nvm_idx = r.nvm_idx + 3'h1;
            if (r.nvm_idx == NVM_LAST) begin
               n.loaded  = 1'b1;
               n.nvm_req = 1'b0;
            end
         end
      end

      // Write channel
      if (i_awvalid && r.awready) begin
         n.awaddr  = i_awaddr;
         n.aw_got  = 1'b1;
         n.awready = 1'b0;
      end
      if (i_wvalid && r.wready) begin
         n.wdata  = i_wdata;
         n.wstrb  = i_wstrb;
         n.w_got  = 1'b1;
         n.wready = 1'b0;
      end
      if (wr_do) begin
         n.aw_got = 1'b0;
         n.w_got  = 1'b0;
         n.bvalid = 1'b1;
         n.bresp  = map_ok(r.awaddr) ? RESP_OKAY : RESP_SLVERR;
         if (map_ok(r.awaddr)) begin
            n.cfg = cfg_wr(n.cfg, r.awaddr, r.wdata, r.wstrb);
         end
      end
      if (r.bvalid && i_bready) begin
         n.bvalid  = 1'b0;
         n.awready = 1'b1;
         n.wready  = 1'b1;
      end

      // Read channel
      if (i_arvalid && r.arready) begin
         n.arready = 1'b0;
         n.rvalid  = 1'b1;
         n.rresp   = map_ok(i_araddr) ? RESP_OKAY : RESP_SLVERR;
         n.rdata   = (i_araddr == A_STAT)
                     ? {27'h0000000, r.loaded, r.mod_bit, pa_on, r.state}
                     : cfg_rd(r.cfg, i_araddr);
      end
      if (r.rvalid && i_rready) begin
         n.rvalid  = 1'b0;
         n.arready = 1'b1;
      end

      // Working states
      case (r.state)
         ST_SLEEP: begin
            if (r.loaded && start_edge) begin
               n.state = ST_OSC;
               n.cnt   = '0;
            end
         end
         ST_OSC: begin
            if (r.cnt == CW'(P_OSC_CYC - 1)) begin
               n.state = ST_TUNE;
               n.cnt   = '0;
            end else begin
               n.cnt = r.cnt + CW'(1);
            end
         end
         ST_TUNE: begin
            if (r.cnt == CW'(P_TUNE_CYC - 1)) begin
               n.state  = ST_TX;
               n.cnt    = '0;
               n.pre    = '0;
               n.low_ms = '0;
            end else begin
               n.cnt = r.cnt + CW'(1);
            end
         end
         ST_TX: begin
            if (d_sync) begin
               n.pre    = '0;
               n.low_ms = '0;
            end else if (r.pre == PW'(P_MS_CYC - 1)) begin
               n.pre    = '0;
               n.low_ms = r.low_ms + 7'h01;
               if (r.low_ms + 7'h01 == stop_ms(r.cfg.stop)) begin
                  n.state = ST_SLEEP;
               end
            end else begin
               n.pre = r.pre + PW'(1);
            end
         end
         default: begin
            n.state = ST_SLEEP;
         end
      endcase
      if (core_cmd) begin
         n.state = ST_SLEEP;
      end

      // Enables and modulated bit
      n.osc_en   = (n.state != ST_SLEEP);
      n.synth_en = (n.state == ST_TUNE) || (n.state == ST_TX);
      n.tx_bit   = (n.state == ST_TX) && d_sync;
      n.mod_bit  = (n.state == ST_TX) && (d_sync ^ r.cfg.pol);

      if (!i_rst_n) begin
         n         = '0;
         n.state   = ST_SLEEP;
         n.cfg     = CFG_RST;
         n.awready = 1'b1;
         n.wready  = 1'b1;
         n.arready = 1'b1;
      end
   end

   always_ff @(posedge i_core_clk) begin
      r <= n;
   end

   assign o_awready     = r.awready;
   assign o_wready      = r.wready;
   assign o_bvalid      = r.bvalid;
   assign o_bresp       = r.bresp;
   assign o_arready     = r.arready;
   assign o_rvalid      = r.rvalid;
   assign o_rdata       = r.rdata;
   assign o_rresp       = r.rresp;
   assign o_nvm_req     = r.nvm_req;
   assign o_nvm_addr    = {3'h0, r.nvm_idx, 2'h0};
   assign o_state       = r.state;
   assign o_osc_en      = r.osc_en;
   assign o_synth_en    = r.synth_en;
   assign o_pa_en       = pa_on;
   assign o_mod_bit     = r.mod_bit;
   assign o_mod         = r.cfg.mod;
   assign o_carrier_khz = r.cfg.freq;
   assign o_dev_khz     = r.cfg.dev;
   assign o_pwr_code    = r.cfg.pwr;
   assign o_xtal_load   = r.cfg.xld;
   assign o_sym_rate    = r.cfg.sr;
   assign o_ramp_code   = r.cfg.ramp;

   // Checking helpers
   txsc_state_e h_st;
   int          h_cnt;
   int          h_low;

   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         h_st  <= ST_SLEEP;
         h_cnt <= 0;
         h_low <= 0;
      end else begin
         h_st  <= r.state;
         h_cnt <= (r.state == h_st) ? h_cnt + 1 : 0;
         h_low <= (r.state == ST_TX && !d_sync) ? h_low + 1 : 0;
      end
   end

   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (!i_rst_n);

   AST_SLEEP_EXIT: assert property (
      r.state == ST_SLEEP |=> r.state == ST_SLEEP || r.state == ST_OSC)
      else $error("sleep left for a state other than wake-up");
   AST_SLEEP_OFF: assert property (
      r.state == ST_SLEEP && $past(r.state) == ST_SLEEP
         |-> !o_osc_en && !o_synth_en && !o_pa_en)
      else $error("block powered while sleeping");
   AST_START: assert property (
      r.state == ST_SLEEP && r.loaded && !core_cmd && start_edge
         |=> r.state == ST_OSC && o_osc_en && !o_synth_en)
      else $error("start edge did not wake the oscillator");
   AST_OSC_LEN: assert property (
      r.state == ST_TUNE && h_st == ST_OSC |-> h_cnt == P_OSC_CYC - 1)
      else $error("oscillator wake-up length wrong");
   AST_TUNE_LEN: assert property (
      r.state == ST_TX && h_st == ST_TUNE |-> h_cnt == P_TUNE_CYC - 1)
      else $error("tune length wrong");
   AST_NO_PA: assert property (
      r.state != ST_TX && $past(r.state) != ST_TX |-> !o_pa_en && !o_mod_bit)
      else $error("amplifier or data active before transmit");
   AST_MOD: assert property (
      (r.state == ST_TX && !core_cmd) ##1 r.state == ST_TX
         |-> o_mod_bit == ($past(d_sync) ^ $past(r.cfg.pol)))
      else $error("modulated bit does not follow the data pin");
   AST_STOP: assert property (
      (r.state == ST_TX && !core_cmd) ##1 r.state == ST_SLEEP
         |-> $past(h_low) == int'(stop_ms($past(r.cfg.stop))) * P_MS_CYC - 1)
      else $error("transmit ended after a wrong low-hold time");
   AST_CORE: assert property (
      r.state != ST_SLEEP && core_cmd |=> r.state == ST_SLEEP ##1 !o_pa_en)
      else $error("core reset command did not stop transmission");
   AST_NVM: assert property (
      !r.loaded && r.nvm_req && i_nvm_valid && r.nvm_idx == 3'h1 && !wr_do
         |=> r.cfg.stop == $past(i_nvm_data[3:0]))
      else $error("stored stop setting not loaded");

   COV_START: cover property (r.state == ST_SLEEP ##1 r.state == ST_OSC);
   COV_LOW_STOP: cover property (
      (r.state == ST_TX && !core_cmd) ##1 r.state == ST_SLEEP);
   COV_CORE_STOP: cover property (r.state == ST_TX && core_cmd);
endmodule // txsc_top

// File: dv/txsc_nvm_model.sv
// Settings memory model answering the load requests of the controller
`timescale 1ns/1ps
module txsc_nvm_model #(
   parameter logic [159:0] WORDS = '0
) (
   // Load handshake
   input  wire logic        i_core_clk,
   input  wire logic        i_req,
   input  wire logic [7:0]  i_addr,
   output logic             o_valid,
   output logic [31:0]      o_data
);
   logic slow;
   initial begin
      o_valid = 1'b0;
      o_data  = 32'hA5A5_5A5A;
      slow    = 1'b0;
      forever begin
         @(posedge i_core_clk);
         if (i_req) begin
            repeat (slow ? 3 : 0) @(posedge i_core_clk);
            o_valid <= 1'b1;
            o_data  <= WORDS[i_addr[4:2]*32 +: 32];
            @(posedge i_core_clk);
            o_valid <= 1'b0;
            o_data  <= ~WORDS[i_addr[4:2]*32 +: 32];
            slow = ~slow;
            @(posedge i_core_clk);
         end
      end
   end
endmodule // txsc_nvm_model

// File: dv/txsc_top_bench.sv
// Self-checking bench of the transmit state controller
`timescale 1ns/1ps
module txsc_top_bench import txsc_pkg::*;;
   localparam logic [159:0] NVM_W = {32'h60, 32'hF23, 32'h69F00, 32'h8, 32'h1400};
   logic i_core_clk = 1'b0, i_rst_n = 1'b0, i_awvalid = 1'b0, i_wvalid = 1'b0;
   logic i_bready = 1'b0, i_arvalid = 1'b0, i_rready = 1'b0, i_data_pin = 1'b0;
   logic i_core_rst_cmd = 1'b0;
   logic [7:0] i_awaddr = 8'h00, i_araddr = 8'h00, o_nvm_addr;
   logic [31:0] i_wdata = 32'h0, o_rdata, i_nvm_data;
   logic [3:0] i_wstrb = 4'hF, o_pa_level, o_ramp_code;
   logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_nvm_req, i_nvm_valid;
   logic o_osc_en, o_synth_en, o_pa_en, o_mod_bit;
   logic [1:0] o_bresp, o_rresp, o_state, o_mod;
   logic [19:0] o_carrier_khz;
   logic [6:0] o_dev_khz;
   logic [5:0] o_xtal_load;
   logic [9:0] o_sym_rate;
   logic [4:0] o_pwr_code, p;
   logic [33:0] expq[$];
   int miscompares = 0, comparisons = 0, seed = 81;

   always #2.5 i_core_clk = ~i_core_clk;

   txsc_top #(.P_OSC_CYC(20), .P_TUNE_CYC(15), .P_MS_CYC(50)) DUT (
      .i_core_clk, .i_rst_n, .i_awvalid, .o_awready, .i_awaddr, .i_wvalid, .o_wready,
      .i_wdata, .i_wstrb, .o_bvalid, .i_bready, .o_bresp, .i_arvalid, .o_arready,
      .i_araddr, .o_rvalid, .i_rready, .o_rdata, .o_rresp, .i_data_pin, .i_core_rst_cmd,
      .o_nvm_req, .o_nvm_addr, .i_nvm_valid, .i_nvm_data, .o_state, .o_osc_en, .o_synth_en,
      .o_pa_en, .o_pa_level, .o_mod_bit, .o_mod, .o_carrier_khz, .o_dev_khz,
      .o_pwr_code, .o_xtal_load, .o_sym_rate, .o_ramp_code);

   txsc_nvm_model #(.WORDS(NVM_W)) NVM (.i_core_clk, .i_req(o_nvm_req),
      .i_addr(o_nvm_addr), .o_valid(i_nvm_valid), .o_data(i_nvm_data));

   task automatic chk_sig(input logic [33:0] e, input logic [33:0] g);
      comparisons++;
      if (g !== e) begin
         miscompares++;
         $display("unexpected at %0t: exp %h got %h", $time, e, g);
      end
   endtask

   task automatic chk_bus(input logic [33:0] e, input logic [33:0] g);
      chk_sig(e, g);
   endtask

   task automatic done(input string s);
      $display("test %s finished", s);
   endtask

   task automatic final_report;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   // Register write, either channel may be taken first
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      logic aw, w;
      expq.push_back({r, 32'h0});
      i_awaddr <= a;
      i_wdata <= d;
      i_awvalid <= 1'b1;
      i_wvalid <= 1'b1;
      i_bready <= 1'b1;
      aw = 1'b0;
      w = 1'b0;
      do begin
         @(posedge i_core_clk);
         if (o_awready && !aw) begin
            aw = 1'b1;
            i_awvalid <= 1'b0;
         end
         if (o_wready && !w) begin
            w = 1'b1;
            i_wvalid <= 1'b0;
         end
      end while (!(aw && w));
      do @(posedge i_core_clk); while (!o_bvalid);
      i_bready <= 1'b0;
      @(posedge i_core_clk);
   endtask

   task automatic rd(input logic [7:0] a, input logic [33:0] e);
      expq.push_back(e);
      i_araddr <= a;
      i_arvalid <= 1'b1;
      i_rready <= 1'b1;
      do @(posedge i_core_clk); while (!o_arready);
      i_arvalid <= 1'b0;
      do @(posedge i_core_clk); while (!o_rvalid);
      i_rready <= 1'b0;
      @(posedge i_core_clk);
   endtask

   // Runs until a state shows, counting edges; amplifier idle in wake-up and tune
   task automatic run_to(input logic [1:0] s, input int lim, input logic rnd, output int n);
      n = 0;
      do begin
         if (rnd) i_data_pin <= 1'($random(seed));
         @(posedge i_core_clk);
         n++;
         if (o_state === ST_OSC || o_state === ST_TUNE) chk_sig(0, {o_pa_en, o_mod_bit});
      end while (o_state !== s && n < lim);
   endtask

   always @(posedge i_core_clk) begin
      if (o_rvalid && i_rready) chk_bus(expq.pop_front(), {o_rresp, o_rdata});
      if (o_bvalid && i_bready) chk_bus(expq.pop_front(), {o_bresp, 32'h0});
   end

   initial begin
      repeat (20000) @(posedge i_core_clk);
      miscompares++;
      final_report;
   end

   initial begin
      int n, ms;
      repeat (2) @(posedge i_core_clk);
      i_rst_n <= 1'b1;
      while (o_nvm_req !== 1'b1) @(posedge i_core_clk);
      chk_sig({20'hD3FFE, 7'h23}, {o_carrier_khz, o_dev_khz});
      chk_sig({6'h0F, 10'h018, 2'h0}, {o_xtal_load, o_sym_rate, o_mod});
      while (o_nvm_req !== 1'b0) @(posedge i_core_clk);
      for (int i = 0; i < 5; i++) rd(8'(i * 4), {RESP_OKAY, NVM_W[i*32 +: 32]});
      rd(8'h18, {RESP_SLVERR, 32'h0});
      wr(A_STAT, 32'h0, RESP_OKAY);
      wr(8'h06, 32'h0, RESP_SLVERR);
      chk_sig({NVM_W[64 +: 20], NVM_W[96 +: 7]}, {o_carrier_khz, o_dev_khz});
      chk_sig({NVM_W[104 +: 6], NVM_W[128 +: 10]}, {o_xtal_load, o_sym_rate});
      chk_sig(NVM_W[7:2], {o_ramp_code, o_mod});
      done("settings");
      p = 5'($unsigned($random(seed)) % 24);
      ms = $unsigned($random(seed)) % 16;
      wr(A_STOP, 32'(ms), RESP_OKAY);
      ms = (ms < 8) ? ms + 2 : (ms - 6) * 10;
      wr(A_CTRL, {19'h0, p, 8'h00}, RESP_OKAY);
      rd(A_CTRL, {RESP_OKAY, 19'h0, p, 8'h00});
      chk_sig(34'(p), 34'(o_pwr_code));
      i_data_pin <= 1'b1;
      run_to(ST_OSC, 10, 1'b0, n);
      chk_sig(34'h3, {o_osc_en, o_state == ST_OSC});
      run_to(ST_TUNE, 100, 1'b1, n);
      chk_sig(34'd20, 34'(n));
      run_to(ST_TX, 100, 1'b1, n);
      chk_sig(34'd15, 34'(n));
      i_data_pin <= 1'b1;
      repeat (5) @(posedge i_core_clk);
      chk_sig(34'h31, {o_pa_en, o_pa_level, o_mod_bit});
      i_data_pin <= 1'b0;
      run_to(ST_SLEEP, 5000, 1'b0, n);
      chk_sig(34'h1, 34'(n >= ms * 50 && n <= ms * 50 + 6));
      @(posedge i_core_clk);
      chk_sig(34'h0, {o_osc_en, o_synth_en, o_pa_en});
      done("rising start");
      wr(A_CTRL, {19'h0, p, 8'h03}, RESP_OKAY);
      i_data_pin <= 1'b1;
      repeat (8) @(posedge i_core_clk);
      chk_sig(34'(ST_SLEEP), 34'(o_state));
      i_data_pin <= 1'b0;
      run_to(ST_TUNE, 100, 1'b0, n);
      run_to(ST_TX, 100, 1'b1, n);
      i_data_pin <= 1'b1;
      repeat (5) @(posedge i_core_clk);
      chk_sig(34'h30, {o_pa_en, o_pa_level, o_mod_bit});
      wr(A_CTRL, {15'h0, 1'b1, 3'h0, p, 8'h03}, RESP_OKAY);
      run_to(ST_SLEEP, 60, 1'b0, n);
      chk_sig(34'(ST_SLEEP), 34'(o_state));
      done("falling start");
      wr(A_CTRL, {19'h0, p, 8'h18}, RESP_OKAY);
      i_data_pin <= 1'b0;
      repeat (5) @(posedge i_core_clk);
      i_data_pin <= 1'b1;
      run_to(ST_TX, 100, 1'b0, n);
      repeat (10) @(posedge i_core_clk);
      chk_sig(34'h1, 34'(o_pa_level < 4'h8));
      repeat (390) @(posedge i_core_clk);
      chk_sig(34'h8, 34'(o_pa_level));
      rd(A_STAT, {RESP_OKAY, 32'h0000001F});
      i_data_pin <= 1'b0;
      repeat (40) @(posedge i_core_clk);
      chk_sig(34'h1, 34'(o_pa_level != 4'h0 && o_pa_level < 4'h8));
      i_core_rst_cmd <= 1'b1;
      @(posedge i_core_clk);
      i_core_rst_cmd <= 1'b0;
      run_to(ST_SLEEP, 60, 1'b0, n);
      chk_sig(34'h1, 34'(n <= 2));
      done("ramp and command");
      final_report;
   end
endmodule // txsc_top_bench
